// [hw/i2c_intr_consts.vh]
// Offsets, field positions and reset values of the interrupt status block
`ifndef I2C_INTR_CONSTS_VH
`define I2C_INTR_CONSTS_VH

// ---------------------------------------------------------------------
// Register byte addresses
// ---------------------------------------------------------------------
`define ADDR_MASKED_INTERRUPT_STATUS 32'h5000132C
`define ADDR_INTERRUPT_MASK          32'h50001330
`define ADDR_RAW_INTERRUPT_STATUS    32'h50001334

// ---------------------------------------------------------------------
// Status bit positions
// ---------------------------------------------------------------------
`define BIT_RX_UNDER     0
`define BIT_RX_OVER      1
`define BIT_RX_FULL      2
`define BIT_TX_OVER      3
`define BIT_TX_EMPTY     4
`define BIT_RD_REQ       5
`define BIT_TX_ABORT     6
`define BIT_RX_DONE      7
`define BIT_ACTIVITY     8
`define BIT_STOP_SEEN    9
`define BIT_START_SEEN   10
`define BIT_BROADCAST    11

// ---------------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------------
`define SOURCE_COUNT     12
`define REG_WIDTH        16
`define MASK_RESET       12'h8FF
`define STATUS_RESET     12'h000
`define RX_FIFO_DEPTH    32
`define RX_DATA_WIDTH    8

`endif

// [hw/rx_fifo_mem.v]
// Receive FIFO storage with registered read data
`timescale 1ns/100ps
`default_nettype none

module rx_fifo_mem
#(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
)
(
    input  wire             clk_sys,
    input  wire             reset,
    input  wire             writeEn,
    input  wire [AW-1:0]    writeAddr,
    input  wire [WIDTH-1:0] writeData,
    input  wire             readEn,
    input  wire [AW-1:0]    readAddr,
    output reg  [WIDTH-1:0] readData_ff
);

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    reg [WIDTH-1:0] store [0:DEPTH-1];

    always @(posedge clk_sys)
    begin
        if (writeEn)
        begin
            store[writeAddr] <= writeData;
        end
    end

    // Registered read so the top sees a flop
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            readData_ff <= {WIDTH{1'b0}};
        end
        else if (readEn)
        begin
            readData_ff <= store[readAddr];
        end
    end

endmodule

`default_nettype wire

// [hw/i2c_interrupt_status_mask.v]
// I2C controller receive FIFO and interrupt status, mask and view
`timescale 1ns/100ps
`default_nettype none
`include "i2c_intr_consts.vh"

module i2c_interrupt_status_mask
#(
    parameter DEPTH = `RX_FIFO_DEPTH,
    parameter AW    = 5
)
(
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        controllerEnable,
    input  wire        engineActive,
    input  wire [5:0]  receiveLevelThreshold,
    input  wire        rxByteValid,
    input  wire [7:0]  rxByte,
    input  wire        broadcastAcked,
    input  wire        startConditionSeen,
    input  wire        stopConditionSeen,
    input  wire        startClearRead,
    input  wire        stopClearRead,
    input  wire        broadcastClearRead,
    input  wire        dataCommandRead,
    input  wire        regWrite,
    input  wire        regRead,
    input  wire [31:0] regAddr,
    input  wire [15:0] regWriteData,
    output reg  [15:0] regReadData_ff,
    output wire [7:0]  rxData_ff,
    output reg         rxByteAck_ff,
    output reg         internalEnable_ff,
    output reg  [5:0]  rxLevel_ff,
    output reg         interrupt_ff
);

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function addrHit;
        input [31:0] addr;
        input [31:0] offset;
        begin
            addrHit = (addr == offset);
        end
    endfunction

    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    reg  [AW-1:0]              writePtr_ff;
    reg  [AW-1:0]              readPtr_ff;
    reg  [`SOURCE_COUNT-1:0]   mask_ff;
    reg                        rxFull_ff;
    reg                        rxOver_ff;
    reg                        rxUnder_ff;
    reg                        broadcast_ff;
    reg                        startSeen_ff;
    reg                        stopSeen_ff;

    reg  [AW-1:0]              nxt_writePtr;
    reg  [AW-1:0]              nxt_readPtr;
    reg  [5:0]                 nxt_rxLevel;
    reg                        nxt_rxOver;
    reg                        nxt_rxUnder;
    reg                        nxt_broadcast;
    reg                        nxt_startSeen;
    reg                        nxt_stopSeen;
    reg                        nxt_rxFull;

    wire                       fifoEmpty;
    wire                       fifoFull;
    wire                       pushByte;
    wire                       popByte;
    wire [`SOURCE_COUNT-1:0]   rawStatus;
    wire [`SOURCE_COUNT-1:0]   nxt_rawStatus;
    wire [`SOURCE_COUNT-1:0]   maskedStatus;

    assign fifoEmpty = (rxLevel_ff == 6'h00);
    assign fifoFull  = (rxLevel_ff == DEPTH[5:0]);
    // Full FIFO still acks on the bus, the byte just never lands
    assign pushByte  = controllerEnable & rxByteValid & ~fifoFull;
    assign popByte   = controllerEnable & dataCommandRead & ~fifoEmpty;

    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    // General call payload follows the normal receive path
    rx_fifo_mem
    #(
        .WIDTH (`RX_DATA_WIDTH),
        .DEPTH (DEPTH),
        .AW    (AW)
    )
    u_rxFifo
    (
        .clk_sys     (clk_sys),
        .reset       (reset),
        .writeEn     (pushByte),
        .writeAddr   (writePtr_ff),
        .writeData   (rxByte),
        .readEn      (popByte),
        .readAddr    (readPtr_ff),
        .readData_ff (rxData_ff)
    );

    // -----------------------------------------------------------------
    // FIFO pointers and level
    // -----------------------------------------------------------------
    always @*
    begin
        nxt_writePtr = writePtr_ff;
        nxt_readPtr  = readPtr_ff;
        nxt_rxLevel  = rxLevel_ff;
        if (!controllerEnable)
        begin
            // Flushed and held while disabled, bus traffic or not
            nxt_writePtr = {AW{1'b0}};
            nxt_readPtr  = {AW{1'b0}};
            nxt_rxLevel  = 6'h00;
        end
        else
        begin
            if (pushByte)
            begin
                nxt_writePtr = writePtr_ff + 1'b1;
            end
            if (popByte)
            begin
                nxt_readPtr = readPtr_ff + 1'b1;
            end
            if (pushByte && !popByte)
            begin
                nxt_rxLevel = rxLevel_ff + 6'h01;
            end
            else if (popByte && !pushByte)
            begin
                nxt_rxLevel = rxLevel_ff - 6'h01;
            end
        end
    end

    // -----------------------------------------------------------------
    // Raw status flags
    // -----------------------------------------------------------------
    always @*
    begin
        // Level flag follows the next level, no software clear needed
        nxt_rxFull = controllerEnable
                   & (nxt_rxLevel >= receiveLevelThreshold);

        // Set wins over the disable clear in the same cycle
        nxt_rxOver = rxOver_ff;
        if (!internalEnable_ff)
        begin
            nxt_rxOver = 1'b0;
        end
        if (controllerEnable && rxByteValid && fifoFull)
        begin
            nxt_rxOver = 1'b1;
        end

        nxt_rxUnder = rxUnder_ff;
        if (!internalEnable_ff)
        begin
            nxt_rxUnder = 1'b0;
        end
        if (dataCommandRead && fifoEmpty)
        begin
            nxt_rxUnder = 1'b1;
        end

        nxt_broadcast = broadcast_ff;
        if (!controllerEnable || broadcastClearRead)
        begin
            nxt_broadcast = 1'b0;
        end
        if (controllerEnable && broadcastAcked)
        begin
            nxt_broadcast = 1'b1;
        end

        nxt_startSeen = startSeen_ff;
        if (!internalEnable_ff || startClearRead)
        begin
            nxt_startSeen = 1'b0;
        end
        if (startConditionSeen)
        begin
            nxt_startSeen = 1'b1;
        end

        nxt_stopSeen = stopSeen_ff;
        if (!internalEnable_ff || stopClearRead)
        begin
            nxt_stopSeen = 1'b0;
        end
        if (stopConditionSeen)
        begin
            nxt_stopSeen = 1'b1;
        end
    end

    // Transmit-side sources live elsewhere and read as zero here
    assign rawStatus = {broadcast_ff, startSeen_ff, stopSeen_ff,
                        6'h00, rxFull_ff, rxOver_ff, rxUnder_ff};
    assign nxt_rawStatus = {nxt_broadcast, nxt_startSeen, nxt_stopSeen,
                            6'h00, nxt_rxFull, nxt_rxOver, nxt_rxUnder};
    assign maskedStatus = rawStatus & mask_ff;

    // -----------------------------------------------------------------
    // Sequential state
    // -----------------------------------------------------------------
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            writePtr_ff       <= {AW{1'b0}};
            readPtr_ff        <= {AW{1'b0}};
            rxLevel_ff        <= 6'h00;
            rxFull_ff         <= 1'b0;
            rxOver_ff         <= 1'b0;
            rxUnder_ff        <= 1'b0;
            broadcast_ff      <= 1'b0;
            startSeen_ff      <= 1'b0;
            stopSeen_ff       <= 1'b0;
            internalEnable_ff <= 1'b0;
            rxByteAck_ff      <= 1'b0;
            interrupt_ff      <= 1'b0;
        end
        else
        begin
            writePtr_ff  <= nxt_writePtr;
            readPtr_ff   <= nxt_readPtr;
            rxLevel_ff   <= nxt_rxLevel;
            rxFull_ff    <= nxt_rxFull;
            rxOver_ff    <= nxt_rxOver;
            rxUnder_ff   <= nxt_rxUnder;
            broadcast_ff <= nxt_broadcast;
            startSeen_ff <= nxt_startSeen;
            stopSeen_ff  <= nxt_stopSeen;
            // Internal enable lingers until both state machines idle
            internalEnable_ff <= controllerEnable | engineActive;
            // Every byte received while enabled is acked, even when dropped
            rxByteAck_ff <= controllerEnable & rxByteValid;
            // Uses next values so the pin tracks the status flops
            interrupt_ff <= |(nxt_rawStatus & mask_ff);
        end
    end

    // -----------------------------------------------------------------
    // Register access
    // -----------------------------------------------------------------
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            mask_ff <= `MASK_RESET;
        end
        else if (regWrite && addrHit(regAddr, `ADDR_INTERRUPT_MASK))
        begin
            mask_ff <= regWriteData[`SOURCE_COUNT-1:0];
        end
    end

    // Unmapped reads return zero, reserved upper bits as well
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            regReadData_ff <= 16'h0000;
        end
        else if (regRead)
        begin
            if (addrHit(regAddr, `ADDR_MASKED_INTERRUPT_STATUS))
            begin
                regReadData_ff <= {4'h0, maskedStatus};
            end
            else if (addrHit(regAddr, `ADDR_INTERRUPT_MASK))
            begin
                regReadData_ff <= {4'h0, mask_ff};
            end
            else if (addrHit(regAddr, `ADDR_RAW_INTERRUPT_STATUS))
            begin
                regReadData_ff <= {4'h0, rawStatus};
            end
            else
            begin
                regReadData_ff <= 16'h0000;
            end
        end
    end

endmodule

`default_nettype wire

// [tb/i2c_status_monitor.sv]
// Concurrent checks on the interrupt status block ports
`timescale 1ns/100ps
`default_nettype none
`include "i2c_intr_consts.vh"
module i2c_status_monitor
#(
    parameter DEPTH = 32
)
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        controllerEnable,
    input wire logic        engineActive,
    input wire logic [5:0]  receiveLevelThreshold,
    input wire logic        rxByteValid,
    input wire logic [7:0]  rxByte,
    input wire logic        broadcastAcked,
    input wire logic        startConditionSeen,
    input wire logic        stopConditionSeen,
    input wire logic        startClearRead,
    input wire logic        stopClearRead,
    input wire logic        broadcastClearRead,
    input wire logic        dataCommandRead,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic [15:0] regReadData_ff,
    input wire logic [7:0]  rxData_ff,
    input wire logic        rxByteAck_ff,
    input wire logic        internalEnable_ff,
    input wire logic [5:0]  rxLevel_ff,
    input wire logic        interrupt_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // ---------------------------------------------------------------
    // Named steps
    // ---------------------------------------------------------------
    sequence pushIn;
        rxByteValid && controllerEnable && !dataCommandRead;
    endsequence
    // No source may set a flag while everything winds down
    sequence quietOff;
        !controllerEnable && !engineActive && !startConditionSeen
            && !stopConditionSeen && !broadcastAcked && !dataCommandRead;
    endsequence
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    chk_push_ack:
        assert property (rxByteValid && controllerEnable |=> rxByteAck_ff)
        else $error("byte not acknowledged");
    chk_off_noack:
        assert property (rxByteValid && !controllerEnable |=> !rxByteAck_ff)
        else $error("byte acknowledged while disabled");
    chk_level_up:
        assert property (pushIn ##0 (rxLevel_ff < DEPTH)
            |=> rxLevel_ff == $past(rxLevel_ff) + 6'h01)
        else $error("level did not rise on push");
    chk_full_drop:
        assert property (pushIn ##0 (rxLevel_ff == DEPTH)
            |=> rxLevel_ff == DEPTH)
        else $error("byte stored into a full buffer");
    chk_flush_off:
        assert property (!controllerEnable |=> rxLevel_ff == 6'h00)
        else $error("buffer not flushed when disabled");
    chk_pop_down:
        assert property (controllerEnable && dataCommandRead && !rxByteValid
            && rxLevel_ff != 6'h00
            |=> rxLevel_ff == $past(rxLevel_ff) - 6'h01)
        else $error("level did not fall on pop");
    chk_idle_clear:
        assert property (quietOff [*3] |=> !interrupt_ff)
        else $error("interrupt left high after idle disable");
    chk_mask_zero:
        assert property (regWrite && regAddr == `ADDR_INTERRUPT_MASK
            && regWriteData[11:0] == 12'h000 ##1 !regWrite |=> !interrupt_ff)
        else $error("interrupt high with all sources masked");
    chk_reserved_zero:
        assert property (regRead |=> regReadData_ff[15:12] == 4'h0)
        else $error("reserved bits read nonzero");
endmodule
bind i2c_interrupt_status_mask i2c_status_monitor #(.DEPTH(DEPTH)) uMon
(
    .clk_sys, .reset, .controllerEnable, .engineActive,
    .receiveLevelThreshold, .rxByteValid, .rxByte, .broadcastAcked,
    .startConditionSeen, .stopConditionSeen, .startClearRead,
    .stopClearRead, .broadcastClearRead, .dataCommandRead, .regWrite,
    .regRead, .regAddr, .regWriteData, .regReadData_ff, .rxData_ff,
    .rxByteAck_ff, .internalEnable_ff, .rxLevel_ff, .interrupt_ff
);
`default_nettype wire

// [tb/bus_peer_model.sv]
// Behavioural model of the external devices on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module bus_peer_model
(
    input  wire logic       clk_sys,
    input  wire logic       rxByteAck_ff,
    output var  logic       rxByteValid,
    output var  logic [7:0] rxByte,
    output var  logic       broadcastAcked,
    output var  logic       startConditionSeen,
    output var  logic       stopConditionSeen
);
    integer acks = 0;
    initial
    begin
        rxByteValid = 1'b0;
        rxByte = 8'h00;
        broadcastAcked = 1'b0;
        startConditionSeen = 1'b0;
        stopConditionSeen = 1'b0;
    end
    always @(posedge clk_sys)
        if (rxByteAck_ff)
            acks <= acks + 1;
    // Frame: start, optional acked broadcast address, bytes, stop
    task automatic frame(input logic bc, input int n, input logic [7:0] f);
        int i;
        @(negedge clk_sys);
        startConditionSeen = 1'b1;
        @(negedge clk_sys);
        startConditionSeen = 1'b0;
        broadcastAcked = bc;
        @(negedge clk_sys);
        broadcastAcked = 1'b0;
        for (i = 0; i < n; i++)
        begin
            rxByte = f + i[7:0];
            rxByteValid = 1'b1;
            @(negedge clk_sys);
            rxByteValid = 1'b0;
            rxByte = ~rxByte; // Released data never shows the last byte
            @(negedge clk_sys);
        end
        stopConditionSeen = 1'b1;
        @(negedge clk_sys);
        stopConditionSeen = 1'b0;
    endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the interrupt status, mask and receive buffer
`timescale 1ns/100ps
`default_nettype none
`include "i2c_intr_consts.vh"
module tb_top;
    logic        clk_sys = 1'b0, reset = 1'b1;
    logic        controllerEnable = 1'b0, engineActive = 1'b0;
    logic [5:0]  receiveLevelThreshold = 6'h02;
    logic        startClearRead = 1'b0, stopClearRead = 1'b0;
    logic        broadcastClearRead = 1'b0, dataCommandRead = 1'b0;
    logic        regWrite = 1'b0, regRead = 1'b0;
    logic [31:0] regAddr = 32'h00000000;
    logic [15:0] regWriteData = 16'h0000;
    wire  [15:0] regReadData_ff;
    wire  [7:0]  rxData_ff, rxByte;
    wire  [5:0]  rxLevel_ff;
    wire         rxByteAck_ff, internalEnable_ff, interrupt_ff, rxByteValid;
    wire         broadcastAcked, startConditionSeen, stopConditionSeen;
    integer      fails = 0, testsRun = 0, cycles = 0, acks0, i;
    typedef struct packed {logic wr; logic [31:0] a; logic [15:0] v;} row_t;
    row_t        rows [0:11];
    always #25 clk_sys = ~clk_sys;
    i2c_interrupt_status_mask DUT
    (
        .clk_sys, .reset, .controllerEnable, .engineActive,
        .receiveLevelThreshold, .rxByteValid, .rxByte, .broadcastAcked,
        .startConditionSeen, .stopConditionSeen, .startClearRead,
        .stopClearRead, .broadcastClearRead, .dataCommandRead, .regWrite,
        .regRead, .regAddr, .regWriteData, .regReadData_ff, .rxData_ff,
        .rxByteAck_ff, .internalEnable_ff, .rxLevel_ff, .interrupt_ff
    );
    bus_peer_model peer
    (
        .clk_sys, .rxByteAck_ff, .rxByteValid, .rxByte, .broadcastAcked,
        .startConditionSeen, .stopConditionSeen
    );
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string n, input logic [15:0] s, e);
        testsRun++;
        if (s !== e)
        begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task automatic regAccess(input logic wr, input logic [31:0] a,
                             input logic [15:0] d);
        @(negedge clk_sys);
        regWrite = wr;
        regRead = ~wr;
        regAddr = a;
        regWriteData = d;
        @(negedge clk_sys);
        regWrite = 1'b0;
        regRead = 1'b0;
    endtask
    task automatic raw(input logic [15:0] e);
        regAccess(1'b0, `ADDR_RAW_INTERRUPT_STATUS, 16'h0000);
        check("raw status", regReadData_ff, e);
    endtask
    // Bits: pop, broadcast clear, start clear, stop clear
    task automatic strobe(input logic [3:0] s);
        @(negedge clk_sys);
        {dataCommandRead, broadcastClearRead, startClearRead,
         stopClearRead} = s;
        @(negedge clk_sys);
        {dataCommandRead, broadcastClearRead, startClearRead,
         stopClearRead} = 4'h0;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Ceiling well above the roughly 170 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            wrap_up;
        end
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        rows = '{'{0, `ADDR_INTERRUPT_MASK, 16'h08FF},
                 '{0, `ADDR_RAW_INTERRUPT_STATUS, 16'h0000},
                 '{0, `ADDR_MASKED_INTERRUPT_STATUS, 16'h0000},
                 '{1, `ADDR_INTERRUPT_MASK, 16'hFFFF},
                 '{0, `ADDR_INTERRUPT_MASK, 16'h0FFF},
                 '{1, `ADDR_RAW_INTERRUPT_STATUS, 16'h1234},
                 '{0, `ADDR_RAW_INTERRUPT_STATUS, 16'h0000},
                 '{0, 32'h50001338, 16'h0000},
                 '{1, `ADDR_INTERRUPT_MASK, 16'h0000},
                 '{0, `ADDR_INTERRUPT_MASK, 16'h0000},
                 '{1, `ADDR_INTERRUPT_MASK, 16'h08FF},
                 '{0, `ADDR_MASKED_INTERRUPT_STATUS, 16'h0000}};
        repeat (12) @(negedge clk_sys);
        reset = 1'b0;
        controllerEnable = 1'b1;
        for (i = 0; i < 12; i++)
        begin
            regAccess(rows[i].wr, rows[i].a, rows[i].v);
            if (!rows[i].wr)
                check("register", regReadData_ff, rows[i].v);
        end
        peer.frame(1'b0, 2, 8'hA0);
        raw(16'h0604);
        check("interrupt", {15'h0000, interrupt_ff}, 16'h0001);
        strobe(4'h8);
        check("rx data", {8'h00, rxData_ff}, 16'h00A0);
        raw(16'h0600);
        strobe(4'h3);
        strobe(4'h8);
        receiveLevelThreshold = 6'h20;
        peer.frame(1'b1, 2, 8'h30);
        raw(16'h0E00);
        regAccess(1'b0, `ADDR_MASKED_INTERRUPT_STATUS, 16'h0000);
        check("masked", regReadData_ff, 16'h0800);
        strobe(4'h4);
        raw(16'h0600);
        strobe(4'h8);
        check("rx data", {8'h00, rxData_ff}, 16'h0030);
        strobe(4'h8);
        check("rx data", {8'h00, rxData_ff}, 16'h0031);
        strobe(4'h8);
        raw(16'h0601);
        acks0 = peer.acks;
        peer.frame(1'b0, 33, 8'h00);
        check("acks", 16'(peer.acks - acks0), 16'h0021);
        check("level", {10'h000, rxLevel_ff}, 16'h0020);
        raw(16'h0607);
        engineActive = 1'b1;
        controllerEnable = 1'b0;
        // Bus traffic keeps coming while disabled
        peer.frame(1'b0, 1, 8'h55);
        check("level", {10'h000, rxLevel_ff}, 16'h0000);
        check("int enable", {15'h0000, internalEnable_ff}, 16'h0001);
        raw(16'h0603);
        engineActive = 1'b0;
        repeat (3) @(negedge clk_sys);
        check("int enable", {15'h0000, internalEnable_ff}, 16'h0000);
        raw(16'h0000);
        check("interrupt", {15'h0000, interrupt_ff}, 16'h0000);
        // Mid-run reset must restore the mask
        regAccess(1'b1, `ADDR_INTERRUPT_MASK, 16'h0000);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        regAccess(1'b0, `ADDR_INTERRUPT_MASK, 16'h0000);
        check("mask reset", regReadData_ff, 16'h08FF);
        raw(16'h0000);
        wrap_up;
    end
endmodule
`default_nettype wire
